// File: shared/amcp_pkg.sv
// amcp_pkg: constants and types of the converter mode configuration port
// assumes: shared by the top module, the serial receiver and the formatter
package amcp_pkg;
  // ------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16; // bits taken per transfer
  localparam int unsigned HDR_BITS = 8; // flag plus address
  localparam int unsigned SAMPLE_W = 14; // converter data width
  typedef logic [6:0] amcp_addr_t;
  typedef logic [7:0] amcp_byte_t;
  // ------------------------------------------------------------
  // register offsets and reset value
  // ------------------------------------------------------------
  localparam amcp_addr_t ADDR_SOFT_RESET = 7'h00;
  localparam amcp_addr_t ADDR_POWER = 7'h01;
  localparam amcp_addr_t ADDR_CLK_TIMING = 7'h02;
  localparam amcp_addr_t ADDR_DRV_MODE = 7'h03;
  localparam amcp_addr_t ADDR_FORMAT = 7'h04;
  localparam amcp_byte_t REG_RESET_VAL = 8'h00;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned SOFT_RESET_BIT = 7;
  localparam int unsigned PWR_LSB = 0;
  localparam int unsigned CLK_DCS_BIT = 0;
  localparam int unsigned CLK_DELAY_LSB = 1;
  localparam int unsigned CLK_INV_BIT = 3;
  localparam int unsigned DRV_IF_LSB = 0;
  localparam int unsigned DRV_DISABLE_BIT = 2;
  localparam int unsigned DRV_TERM_BIT = 3;
  localparam int unsigned DRV_CUR_LSB = 4;
  localparam int unsigned FMT_SIGNED_BIT = 0;
  localparam int unsigned FMT_SCRAMBLE_BIT = 1;
  localparam int unsigned FMT_ODD_INV_BIT = 2;
  localparam int unsigned FMT_TEST_LSB = 3;
  // ------------------------------------------------------------
  // field codes
  // ------------------------------------------------------------
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_SLEEP = 2'h3;
  localparam logic [1:0] IF_CMOS_FULL = 2'h0;
  localparam logic [1:0] IF_LVDS_DDR = 2'h1;
  localparam logic [2:0] CUR_3P5MA = 3'h0;
  localparam logic [2:0] TP_ZEROS = 3'h1;
  localparam logic [2:0] TP_ONES = 3'h3;
  localparam logic [2:0] TP_CHECKER = 3'h5;
  localparam logic [2:0] TP_ALTERNATE = 3'h7;
  localparam logic [14:0] CHECKER_A = 15'h5555; // overflow first
  localparam logic [14:0] CHECKER_B = 15'h2AAA;
  localparam logic [13:0] ODD_BIT_MASK = 14'h2AAA; // bits 1,3..13
  // ------------------------------------------------------------
  // serial receiver states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_HDR = 4'b0010,
    RX_DATA = 4'b0100,
    RX_DONE = 4'b1000
  } amcp_rx_state_e;
endpackage : amcp_pkg

// File: design/amcp_serial_rx.sv
// amcp_serial_rx: four-wire serial receiver of the configuration port
// assumes: async pins; sck far slower than sys_clk
`timescale 1ns/1ps
`default_nettype none
module amcp_serial_rx
  import amcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_en,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire amcp_pkg::amcp_byte_t rd_data,
  output amcp_pkg::amcp_addr_t addr,
  output amcp_pkg::amcp_byte_t wr_data,
  output logic wr_pulse,
  output logic sdo_pull,
  output logic cs_lvl,
  output logic sck_lvl,
  output logic sdi_lvl
);
  // synchronisers and sck history
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic sck_prev_ff;
  amcp_rx_state_e state_ff;
  logic [4:0] cnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  amcp_addr_t addr_ff;
  amcp_byte_t wr_data_ff;
  amcp_byte_t tx_ff;
  logic wr_pulse_ff;
  logic sdo_pull_ff;
  // decode of synchronised levels
  wire cs_s = pin_s2_ff[2];
  wire sck_s = pin_s2_ff[1];
  wire sdi_s = pin_s2_ff[0];
  wire sck_rise = sck_s & ~sck_prev_ff;
  wire sck_fall = ~sck_s & sck_prev_ff;
  wire active = serial_en & ~cs_s;
  wire first_fall = (cnt_ff == 5'(HDR_BITS));
  wire [7:0] out_src = first_fall ? rd_data : tx_ff;
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_s1_ff <= 3'h7;
      pin_s2_ff <= 3'h7;
      sck_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= {cs_n_pin, sck_pin, sdi_pin};
      pin_s2_ff <= pin_s1_ff;
      sck_prev_ff <= pin_s2_ff[1];
    end
  end
  // ------------------------------------------------------------
  // word receiver and read-back shifter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= RX_IDLE;
      cnt_ff <= 5'h00;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      addr_ff <= 7'h00;
      wr_data_ff <= 8'h00;
      tx_ff <= 8'h00;
      wr_pulse_ff <= 1'b0;
      sdo_pull_ff <= 1'b0;
    end else begin
      wr_pulse_ff <= 1'b0;
      if (!active) begin
        // frame over: release sdo, drop word
        state_ff <= RX_IDLE;
        cnt_ff <= 5'h00;
        sdo_pull_ff <= 1'b0;
      end else begin
        case (state_ff)
          RX_IDLE: state_ff <= RX_HDR;
          RX_HDR: begin
            if (sck_rise) begin
              shift_ff <= {shift_ff[6:0], sdi_s};
              cnt_ff <= cnt_ff + 5'h01;
              if (cnt_ff == 5'(HDR_BITS - 1)) begin
                rw_ff <= shift_ff[6];
                addr_ff <= {shift_ff[5:0], sdi_s};
                state_ff <= RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (sck_rise) begin
              shift_ff <= {shift_ff[6:0], sdi_s};
              cnt_ff <= cnt_ff + 5'h01;
              if (cnt_ff == 5'(WORD_BITS - 1)) begin
                // 16th edge: write unless read-back
                wr_data_ff <= {shift_ff[6:0], sdi_s};
                wr_pulse_ff <= ~rw_ff;
                state_ff <= RX_DONE;
              end
            end else if (sck_fall) begin
              // read: pull low for a 0 bit
              sdo_pull_ff <= rw_ff & ~out_src[7];
              tx_ff <= {out_src[6:0], 1'b0};
            end
          end
          RX_DONE: begin
            // further rises ignored; release after last bit
            if (sck_fall) sdo_pull_ff <= 1'b0;
          end
          default: state_ff <= RX_IDLE;
        endcase
      end
    end
  end
  assign addr = addr_ff;
  assign wr_data = wr_data_ff;
  assign wr_pulse = wr_pulse_ff;
  assign sdo_pull = sdo_pull_ff;
  assign cs_lvl = cs_s;
  assign sck_lvl = sck_s;
  assign sdi_lvl = sdi_s;
endmodule : amcp_serial_rx
`default_nettype wire

// File: design/amcp_data_fmt.sv
// amcp_data_fmt: output data formatter
// assumes: raw samples are offset binary, strobed on sys_clk
`timescale 1ns/1ps
`default_nettype none
module amcp_data_fmt
  import amcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sample_strobe,
  input wire logic [amcp_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic sample_ovf,
  input wire logic [2:0] test_pattern,
  input wire logic odd_inv,
  input wire logic scramble,
  input wire logic signed_sel,
  output logic [amcp_pkg::SAMPLE_W-1:0] data_out,
  output logic ovf_out
);
  logic [14:0] word_ff; // overflow on top
  logic phase_ff; // pattern alternation
  // formatting chain
  wire signed_eff = signed_sel & ~odd_inv;
  wire [13:0] step_sign = {sample_data[13] ^ signed_eff, sample_data[12:0]};
  wire [13:0] step_scr = scramble ?
    {step_sign[13:1] ^ {13{step_sign[0]}}, step_sign[0]} : step_sign;
  wire [13:0] step_odd = odd_inv ? (step_scr ^ ODD_BIT_MASK) : step_scr;
  // pattern select, unused codes pass data
  logic [14:0] pat;
  logic pat_on;
  always_comb begin
    pat = 15'h0000;
    pat_on = 1'b1;
    case (test_pattern)
      TP_ZEROS: pat = 15'h0000;
      TP_ONES: pat = 15'h7FFF;
      TP_CHECKER: pat = phase_ff ? CHECKER_B : CHECKER_A;
      TP_ALTERNATE: pat = phase_ff ? 15'h7FFF : 15'h0000;
      default: pat_on = 1'b0;
    endcase
  end
  // ------------------------------------------------------------
  // output register, once per sample
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      word_ff <= 15'h0000;
      phase_ff <= 1'b0;
    end else if (sample_strobe) begin
      word_ff <= pat_on ? pat : {sample_ovf, step_odd};
      phase_ff <= ~phase_ff;
    end
  end
  assign data_out = word_ff[13:0];
  assign ovf_out = word_ff[14];
endmodule : amcp_data_fmt
`default_nettype wire

// File: design/amcp_config_port.sv
// amcp_config_port: mode configuration port of a sampling data converter
// assumes: pins async to sys_clk; samples on sys_clk
//
// Overview of operation
// - style pin high makes pins static straps
// - strap cs sets stabilizer, sdi sets sleep
// - strap sck picks full CMOS or DDR LVDS
// - style pin low gives 16-bit serial port
// - frame is cs low; first 16 rises sampled
// - word is flag, seven address, eight data
// - flag low writes data to addressed register
// - flag high reads register back on sdo
// - sdo only pulls low, open drain
// - address 00h bit 7 clears all registers
// - address 01h bits 1-0 set power state
// - address 02h bit 3 inverts output clock
// - address 02h bits 2-1 delay output clock
// - address 03h bits 6-4 choose drive current
// - termination on multiplies current by 1.6
// - address 03h bit 2 disables data outputs, not overflow
// - address 03h bits 1-0 select output interface
// - address 04h bits 5-3 choose test pattern
// - bit 0 two's complement unless odd invert
// - bit 1 enables randomizer independently
// - randomizer xors lsb into other data bits
// - odd invert flips odd data bits 1,3..13
// - test pattern overrides all other formatting
`timescale 1ns/1ps
`default_nettype none
module amcp_config_port
  import amcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration pins
  input wire logic programming_style_select,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  output logic sdo_out,
  output logic sdo_oe,
  // raw converter samples
  input wire logic sample_strobe,
  input wire logic [amcp_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic sample_ovf,
  // formatted outputs
  output logic [amcp_pkg::SAMPLE_W-1:0] data_out,
  output logic overflow_flag,
  output logic data_out_en,
  // effective mode settings
  output logic serial_mode,
  output logic duty_cycle_stabilizer_en,
  output logic [1:0] power_state_field,
  output logic out_clock_invert,
  output logic [1:0] out_clock_delay_field,
  output logic [2:0] diff_drive_current_field,
  output logic internal_termination_en,
  output logic [12:0] drive_current_ua,
  output logic output_disable,
  output logic [1:0] output_interface_field
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------

  // style pin synchroniser
  logic style_s1_ff;
  logic style_s2_ff;

  // mode control registers
  amcp_byte_t power_ff;
  amcp_byte_t clk_timing_ff;
  amcp_byte_t drv_mode_ff;
  amcp_byte_t format_ff;

  // registered effective settings
  logic dcs_ff;
  logic [1:0] pwr_ff;
  logic clk_inv_ff;
  logic [1:0] clk_delay_ff;
  logic [2:0] cur_sel_ff;
  logic term_ff;
  logic [12:0] cur_ua_ff;
  logic out_dis_ff;
  logic [1:0] if_sel_ff;
  logic sdo_out_ff;

  // receiver connections
  amcp_addr_t rx_addr;
  amcp_byte_t rx_wr_data;
  logic rx_wr_pulse;
  logic rx_sdo_pull;
  logic cs_lvl;
  logic sck_lvl;
  logic sdi_lvl;
  amcp_byte_t rd_data; // read-back data

  // ------------------------------------------------------------
  // drive current lookup
  // ------------------------------------------------------------

  // microamps per current code, x1.6 with termination
  function automatic logic [12:0] cur_lookup(
    input logic [2:0] code,
    input logic term
  );
    logic [12:0] base;
    base = 13'h0000;
    case (code)
      3'h0: base = 13'd3500;
      3'h1: base = 13'd4000;
      3'h2: base = 13'd4500;
      3'h4: base = 13'd3000;
      3'h5: base = 13'd2500;
      3'h6: base = 13'd2100;
      3'h7: base = 13'd1750;
      default: base = 13'h0000; // unused code
    endcase
    // 1.6 = 8/5; every table entry divides exactly
    if (term) begin
      cur_lookup = 13'((base * 8) / 5);
    end else begin
      cur_lookup = base;
    end
  endfunction : cur_lookup

  // ------------------------------------------------------------
  // programming style
  // ------------------------------------------------------------

  // strap mode while the style pin reads high
  wire strap = style_s2_ff;

  // serial port while pin low
  wire ser_en = ~style_s2_ff;

  // two flops on the style pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      style_s1_ff <= 1'b0;
      style_s2_ff <= 1'b0;
    end else begin
      style_s1_ff <= programming_style_select;
      style_s2_ff <= style_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // serial receiver
  // ------------------------------------------------------------

  amcp_serial_rx u_rx (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .serial_en(ser_en),
    .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin),
    .sdi_pin(sdi_pin),
    .rd_data(rd_data),
    .addr(rx_addr),
    .wr_data(rx_wr_data),
    .wr_pulse(rx_wr_pulse),
    .sdo_pull(rx_sdo_pull),
    .cs_lvl(cs_lvl),
    .sck_lvl(sck_lvl),
    .sdi_lvl(sdi_lvl)
  );

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------

  // address hits
  wire hit_rst = (rx_addr == ADDR_SOFT_RESET);
  wire hit_pwr = (rx_addr == ADDR_POWER);
  wire hit_clk = (rx_addr == ADDR_CLK_TIMING);
  wire hit_drv = (rx_addr == ADDR_DRV_MODE);
  wire hit_fmt = (rx_addr == ADDR_FORMAT);

  // soft reset: bit 7 only, not stored
  wire soft_rst = rx_wr_pulse & hit_rst & rx_wr_data[SOFT_RESET_BIT];

  // per-register write strobes
  wire wr_pwr = rx_wr_pulse & hit_pwr;
  wire wr_clk = rx_wr_pulse & hit_clk;
  wire wr_drv = rx_wr_pulse & hit_drv;
  wire wr_fmt = rx_wr_pulse & hit_fmt;

  // read-back mux; others read zero
  assign rd_data =
    hit_pwr ? power_ff :
    hit_clk ? clk_timing_ff :
    hit_drv ? drv_mode_ff :
    hit_fmt ? format_ff : REG_RESET_VAL;

  // ------------------------------------------------------------
  // mode control registers
  // ------------------------------------------------------------

  // software reset clears every register to 00h
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_rst) begin
      power_ff <= REG_RESET_VAL;
      clk_timing_ff <= REG_RESET_VAL;
      drv_mode_ff <= REG_RESET_VAL;
      format_ff <= REG_RESET_VAL;
    end else begin
      if (wr_pwr) power_ff <= rx_wr_data;
      if (wr_clk) clk_timing_ff <= rx_wr_data;
      if (wr_drv) drv_mode_ff <= rx_wr_data;
      if (wr_fmt) format_ff <= rx_wr_data;
    end
  end

  // ------------------------------------------------------------
  // effective settings
  // ------------------------------------------------------------

  // register fields
  wire [1:0] reg_pwr = power_ff[PWR_LSB +: 2];
  wire reg_dcs = clk_timing_ff[CLK_DCS_BIT];
  wire reg_inv = clk_timing_ff[CLK_INV_BIT];
  wire [1:0] reg_delay = clk_timing_ff[CLK_DELAY_LSB +: 2];
  wire [2:0] reg_cur = drv_mode_ff[DRV_CUR_LSB +: 3];
  wire reg_term = drv_mode_ff[DRV_TERM_BIT];
  wire reg_dis = drv_mode_ff[DRV_DISABLE_BIT];
  wire [1:0] reg_if = drv_mode_ff[DRV_IF_LSB +: 2];

  // strap levels or fixed defaults replace registers
  wire nxt_dcs = strap ? cs_lvl : reg_dcs;
  wire [1:0] nxt_pwr = strap ? (sdi_lvl ? PWR_SLEEP : PWR_NORMAL) : reg_pwr;
  wire [1:0] nxt_if = strap ? (sck_lvl ? IF_LVDS_DDR : IF_CMOS_FULL) : reg_if;
  wire [2:0] nxt_cur = strap ? CUR_3P5MA : reg_cur;
  wire nxt_term = strap ? 1'b0 : reg_term;
  wire nxt_inv = ~strap & reg_inv;
  wire [1:0] nxt_delay = strap ? 2'h0 : reg_delay;
  wire nxt_dis = ~strap & reg_dis;

  // formatter controls, all off in strap mode
  wire [2:0] fmt_pat = strap ? 3'h0 : format_ff[FMT_TEST_LSB +: 3];
  wire fmt_odd = ~strap & format_ff[FMT_ODD_INV_BIT];
  wire fmt_scr = ~strap & format_ff[FMT_SCRAMBLE_BIT];
  wire fmt_sgn = ~strap & format_ff[FMT_SIGNED_BIT];

  // settings registered for flop outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dcs_ff <= 1'b0;
      pwr_ff <= PWR_NORMAL;
      clk_inv_ff <= 1'b0;
      clk_delay_ff <= 2'h0;
      cur_sel_ff <= CUR_3P5MA;
      term_ff <= 1'b0;
      cur_ua_ff <= cur_lookup(CUR_3P5MA, 1'b0);
      out_dis_ff <= 1'b0;
      if_sel_ff <= IF_CMOS_FULL;
      sdo_out_ff <= 1'b0;
    end else begin
      dcs_ff <= nxt_dcs;
      pwr_ff <= nxt_pwr;
      clk_inv_ff <= nxt_inv;
      clk_delay_ff <= nxt_delay;
      cur_sel_ff <= nxt_cur;
      term_ff <= nxt_term;
      cur_ua_ff <= cur_lookup(nxt_cur, nxt_term);
      out_dis_ff <= nxt_dis;
      if_sel_ff <= nxt_if;
      sdo_out_ff <= 1'b0; // only ever drives low
    end
  end

  // ------------------------------------------------------------
  // output data formatter
  // ------------------------------------------------------------

  amcp_data_fmt u_fmt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sample_strobe(sample_strobe),
    .sample_data(sample_data),
    .sample_ovf(sample_ovf),
    .test_pattern(fmt_pat),
    .odd_inv(fmt_odd),
    .scramble(fmt_scr),
    .signed_sel(fmt_sgn),
    .data_out(data_out),
    .ovf_out(overflow_flag)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------

  // open drain: enable high only while pulling a 0 bit
  assign sdo_out = sdo_out_ff;
  assign sdo_oe = rx_sdo_pull;

  // disable drops data_out_en only; overflow_flag not gated
  assign data_out_en = ~out_dis_ff;
  assign serial_mode = ~style_s2_ff;
  assign duty_cycle_stabilizer_en = dcs_ff;
  assign power_state_field = pwr_ff;
  assign out_clock_invert = clk_inv_ff;
  assign out_clock_delay_field = clk_delay_ff;
  assign diff_drive_current_field = cur_sel_ff;
  assign internal_termination_en = term_ff;
  assign drive_current_ua = cur_ua_ff;
  assign output_disable = out_dis_ff;
  assign output_interface_field = if_sel_ff;

endmodule : amcp_config_port
`default_nettype wire

// File: testbench/amcp_config_port_chk.sv
// amcp_config_port_chk: port assertions of the configuration port
// assumes: bound to amcp_config_port, one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module amcp_config_port_chk
  import amcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic programming_style_select,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic sdi_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic serial_mode,
  input wire logic duty_cycle_stabilizer_en,
  input wire logic [1:0] power_state_field,
  input wire logic [2:0] diff_drive_current_field,
  input wire logic internal_termination_en,
  input wire logic [12:0] drive_current_ua,
  input wire logic [1:0] output_interface_field
);
  // ----
  // microamps per code
  // ----
  localparam logic [12:0] UA [8] = '{13'hDAC, 13'hFA0, 13'h1194, 13'h0,
    13'hBB8, 13'h9C4, 13'h834, 13'h6D6};
  logic [12:0] ua_base; // current chosen by code
  logic [15:0] ua_term; // same times 1.6
  assign ua_base = UA[diff_drive_current_field];
  assign ua_term = {3'h0, ua_base} * 16'h8 / 16'h5;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // held pins pass synchronisers
  // ----
  sequence s_cs_idle;
    cs_n_pin [*5];
  endsequence
  sequence s_strap(p);
    (programming_style_select && $stable(p)) [*6];
  endsequence
  a_oe_idle_cs: assert property (s_cs_idle |-> !sdo_oe)
    else $error("sdo pulled while deselected");
  a_sdo_pull_low: assert property (sdo_oe |-> sdo_out == 1'b0)
    else $error("sdo drives high");
  a_oe_in_frame: assert property ($rose(sdo_oe) |-> serial_mode && !cs_n_pin)
    else $error("sdo pulled outside a read frame");
  a_strap_dcs: assert property (s_strap(cs_n_pin) |-> duty_cycle_stabilizer_en == cs_n_pin)
    else $error("strap stabilizer wrong");
  a_strap_sleep: assert property (s_strap(sdi_pin) |-> power_state_field == {2{sdi_pin}})
    else $error("strap power state wrong");
  a_strap_iface: assert property (s_strap(sck_pin) |-> output_interface_field == {1'b0, sck_pin}
    && diff_drive_current_field == 3'h0 && !internal_termination_en)
    else $error("strap output mode wrong");
  a_style_mode: assert property ($stable(programming_style_select) [*5]
    |-> serial_mode == !programming_style_select)
    else $error("programming style not followed");
  a_drive_ua: assert property ($stable(diff_drive_current_field)
    && $stable(internal_termination_en)
    |-> drive_current_ua == (internal_termination_en ? ua_term[12:0] : ua_base))
    else $error("drive current wrong");
endmodule : amcp_config_port_chk
`default_nettype wire

// File: testbench/amcp_host_model.sv
// amcp_host_model: host end of the four-wire configuration link
// assumes: tasks called from the bench; pins move on sys_clk falls
`timescale 1ns/1ps
`default_nettype none
module amcp_host_model (
  input wire logic sys_clk,
  input wire logic sdo_wire,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  localparam int HALF = 4; // half link period, 800 ns total
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // one frame of nrise rises; read bits taken on rises
  task automatic xfer(input logic [15:0] w, input int nrise, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0; // frame opens
    for (int i = 0; i < nrise; i++) begin
      sdi = (i < 16) ? w[15 - i] : ~sdi; // msb first, junk past 16
      repeat (HALF) @(negedge sys_clk);
      if (i >= 8 && i < 16) begin
        rd[15 - i] = sdo_wire;
      end
      sck = 1'b1;
      repeat (HALF) @(negedge sys_clk);
      sck = 1'b0;
    end
    repeat (HALF) @(negedge sys_clk);
    cs_n = 1'b1; // frame closes
    sdi = ~sdi; // released line shows no stale bit
    repeat (HALF) @(negedge sys_clk);
  endtask : xfer
  // static strap levels {cs, sck, sdi}
  task automatic strap(input logic [2:0] v);
    {cs_n, sck, sdi} = v;
  endtask : strap
endmodule : amcp_host_model
`default_nettype wire

// File: testbench/amcp_config_port_tb_top.sv
// amcp_config_port_tb_top: self-checking bench of the configuration port
// assumes: all other files compiled first
`timescale 1ns/1ps
`default_nettype none
module amcp_config_port_tb_top;
  import amcp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n, programming_style_select, sample_strobe, sample_ovf;
  logic [SAMPLE_W-1:0] sample_data;
  wire logic cs_n_pin, sck_pin, sdi_pin, sdo_out, sdo_oe, sdo_wire, overflow_flag;
  wire logic data_out_en, serial_mode, duty_cycle_stabilizer_en, out_clock_invert;
  wire logic internal_termination_en, output_disable;
  wire logic [SAMPLE_W-1:0] data_out;
  wire logic [1:0] power_state_field, out_clock_delay_field, output_interface_field;
  wire logic [2:0] diff_drive_current_field;
  wire logic [12:0] drive_current_ua;
  wire logic [14:0] cfg_got, cfg_exp;
  int error_cnt = 0;
  int compares = 0;
  int nstb = 0; // strobes since reset
  logic [7:0] sh [6]; // expected register contents
  logic [7:0] rd, w;
  logic [6:0] a;
  logic [2:0] sv;
  logic [14:0] e;
  always #50 sys_clk = ~sys_clk;
  assign sdo_wire = sdo_oe ? sdo_out : 1'b1; // pull-up on open drain
  assign cfg_got = {1'b0, power_state_field, out_clock_invert, out_clock_delay_field,
    duty_cycle_stabilizer_en, diff_drive_current_field, internal_termination_en,
    output_disable, output_interface_field, data_out_en};
  assign cfg_exp = {1'b0, sh[1][1:0], sh[2][3:0], sh[3][6:0], ~sh[3][2]};
  amcp_config_port amcp_config_port_inst (.sys_clk, .rst_n, .programming_style_select,
    .cs_n_pin, .sck_pin, .sdi_pin, .sdo_out, .sdo_oe, .sample_strobe, .sample_data,
    .sample_ovf, .data_out, .overflow_flag, .data_out_en, .serial_mode,
    .duty_cycle_stabilizer_en, .power_state_field, .out_clock_invert,
    .out_clock_delay_field, .diff_drive_current_field, .internal_termination_en,
    .drive_current_ua, .output_disable, .output_interface_field);
  amcp_host_model amcp_host_model_inst (.sys_clk(sys_clk), .sdo_wire(sdo_wire),
    .cs_n(cs_n_pin), .sck(sck_pin), .sdi(sdi_pin));
  // ----
  // checking helpers
  // ----
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // reads 00h..05h, then settings
  task automatic chk_regs;
    for (int i = 0; i < 6; i++) begin
      amcp_host_model_inst.xfer({1'b1, 7'(i), 8'($urandom)}, 16, rd);
      chk({7'h0, rd}, {7'h0, sh[i]}, "read back");
    end
    chk(cfg_got, cfg_exp, "settings");
  endtask : chk_regs
  // expected {overflow, data} for a format byte
  function automatic logic [14:0] fmt_exp(logic [7:0] f, logic [13:0] d, logic o, logic ph);
    logic [13:0] v;
    v = d;
    case (f[5:3]) // pattern wins over formatting
      3'h1: return 15'h0;
      3'h3: return 15'h7FFF;
      3'h5: return ph ? 15'h2AAA : 15'h5555;
      3'h7: return ph ? 15'h7FFF : 15'h0;
      default: ;
    endcase
    v[13] = v[13] ^ (f[0] & ~f[2]);
    v[13:1] = f[1] ? v[13:1] ^ {13{v[0]}} : v[13:1];
    v = f[2] ? v ^ 14'h2AAA : v;
    return {o, v};
  endfunction : fmt_exp
  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    #4000000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h56AF));
    {rst_n, programming_style_select, sample_strobe, sample_ovf} = 4'h0;
    sample_data = '0;
    sh = '{default: 8'h00};
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    amcp_host_model_inst.xfer(16'h0080, 16, rd); // first command clears all
    chk_regs();
    for (int n = 0; n < 8; n++) begin
      a = 7'(1 + n % 4);
      w = 8'($urandom);
      if (a == 7'h02) begin
        w[0] = w[0] | (|w[2:1]); // stabilizer on with a delay
      end
      amcp_host_model_inst.xfer({1'b0, a, w}, 16, rd);
      sh[a] = w;
      chk_regs();
    end
    amcp_host_model_inst.xfer({1'b0, 7'h01, ~sh[1]}, 10, rd); // short word dropped
    amcp_host_model_inst.xfer({1'b0, 7'h02, 8'h0B}, 20, rd); // extra rises ignored
    sh[2] = 8'h0B;
    amcp_host_model_inst.xfer({1'b0, 7'($urandom_range(127, 5)), 8'hFF}, 16, rd);
    chk_regs();
    amcp_host_model_inst.xfer({8'h00, 8'h80 | 8'($urandom)}, 16, rd);
    sh = '{default: 8'h00};
    chk_regs();
    for (int n = 0; n < 24; n++) begin
      w = 8'($urandom);
      w[5:3] = 3'(n);
      amcp_host_model_inst.xfer({1'b0, 7'h04, w}, 16, rd);
      repeat (3) begin
        @(negedge sys_clk);
        sample_strobe = 1'b1;
        sample_data = 14'($urandom);
        sample_ovf = 1'($urandom);
        @(negedge sys_clk);
        sample_strobe = 1'b0;
        e = fmt_exp(w, sample_data, sample_ovf, nstb[0]);
        chk({overflow_flag, data_out}, e, "format");
        nstb++;
      end
    end
    programming_style_select = 1'b1; // pins become static straps
    for (int v = 0; v < 8; v++) begin
      sv = 3'(v);
      amcp_host_model_inst.strap(sv);
      repeat (8) @(negedge sys_clk);
      e = {6'h0, sv[2], {2{sv[0]}}, 1'b0, sv[1], 4'h0};
      chk({5'h0, serial_mode, duty_cycle_stabilizer_en, power_state_field,
        output_interface_field, diff_drive_current_field, internal_termination_en},
        e, "strap");
    end
    wrap_up();
  end
endmodule : amcp_config_port_tb_top
bind amcp_config_port amcp_config_port_chk amcp_config_port_chk_inst (.sys_clk, .rst_n,
  .programming_style_select, .cs_n_pin, .sck_pin, .sdi_pin, .sdo_out, .sdo_oe,
  .serial_mode, .duty_cycle_stabilizer_en, .power_state_field, .diff_drive_current_field,
  .internal_termination_en, .drive_current_ua, .output_interface_field);
`default_nettype wire
